// file: logic/motion_detect_result_regs.sv
// result registers, coded restart and motion/stillness detection of the sensor
// assumes host port and sample source are logic on ref_clk; only the interrupt pin level is synchronised
`timescale 1ns/1ns
`include "motion_regs.svh"

// Notes on behaviour
// - z result is 12-bit two's complement: low eight bits, then top four bits.
// - high byte bits 15..12 all copy bit 11 as sign extension.
// - temperature result is 12-bit sign-extended, split low byte and high byte.
// - auxiliary conversion result is 12-bit sign-extended, split low and high byte.
// - writing 0x52 to the restart register clears all settings and enters standby.
// - restart releases the interrupt pin to high impedance; keepers hold its level.
// - restart register is write-only and reads back as 0x00.
// - motion compares each sample magnitude against the unsigned 11-bit threshold.
// - motion threshold is low register eight bits plus three high bits.
// - motion flagged after the dwell count of consecutive samples with an axis above.
// - motion dwell count of zero behaves as one.
// - in wake-up mode the dwell count is ignored; one sample suffices.
// - stillness compares each sample magnitude against the unsigned 11-bit threshold.
// - stillness threshold is low register eight bits plus three high bits.
// - stillness flagged after the 16-bit count of samples with all axes below.
// - stillness count is a low and high byte, up to 0xFFFF samples.
// - stillness count of zero behaves as one.
// - completed motion detection sets the motion flag.
// - completed stillness detection sets the stillness flag.
// - configuration error is set at startup and restart, cleared by any other write.
module motion_detect_result_regs (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// host register port
	input wire motion_pkg::reg_req_t reg_req,
	output logic [7:0] rd_data,
	output logic rd_valid,
	// sensor conversions and mode inputs
	input wire motion_pkg::sample_t sample,
	input wire logic wake_mode,
	input wire logic measure_req,
	input wire logic flag_ack,
	// status
	output logic motion_flag,
	output logic stillness_flag,
	output logic config_error,
	output logic standby,
	// interrupt pin, three-signal form
	input wire logic int_pin_in,
	output logic int_pin_out,
	output logic int_pin_oe
);

	localparam int RW = `RESULT_WIDTH;
	localparam int TW = `THRESHOLD_WIDTH;

	// ==========================================================
	// register request decode
	logic restart_hit;
	logic plain_write;

	assign restart_hit = reg_req.wr && reg_req.addr == `SOFTWARE_RESTART_ADDR &&
		reg_req.wdata == `SOFTWARE_RESTART_CODE;
	assign plain_write = reg_req.wr && !restart_hit;

	// ==========================================================
	// stored settings
	logic [7:0] motion_threshold_low;
	logic [`THRESHOLD_HIGH_BITS-1:0] motion_threshold_high;
	logic [7:0] motion_dwell_count;
	logic [7:0] stillness_threshold_low;
	logic [`THRESHOLD_HIGH_BITS-1:0] stillness_threshold_high;
	logic [7:0] stillness_count_low;
	logic [7:0] stillness_count_high;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			motion_threshold_low <= `REG_RESET_VALUE;
			motion_threshold_high <= '0;
			motion_dwell_count <= `REG_RESET_VALUE;
			stillness_threshold_low <= `REG_RESET_VALUE;
			stillness_threshold_high <= '0;
			stillness_count_low <= `REG_RESET_VALUE;
			stillness_count_high <= `REG_RESET_VALUE;
		end else if (restart_hit) begin
			motion_threshold_low <= `REG_RESET_VALUE;
			motion_threshold_high <= '0;
			motion_dwell_count <= `REG_RESET_VALUE;
			stillness_threshold_low <= `REG_RESET_VALUE;
			stillness_threshold_high <= '0;
			stillness_count_low <= `REG_RESET_VALUE;
			stillness_count_high <= `REG_RESET_VALUE;
		end else if (reg_req.wr) begin
			unique case (reg_req.addr)
				`MOTION_THRESHOLD_LOW_ADDR: motion_threshold_low <= reg_req.wdata;
				// only the three low bits of the high byte are kept
				`MOTION_THRESHOLD_HIGH_ADDR: motion_threshold_high <= reg_req.wdata[`THRESHOLD_HIGH_BITS-1:0];
				`MOTION_DWELL_COUNT_ADDR: motion_dwell_count <= reg_req.wdata;
				`STILLNESS_THRESHOLD_LOW_ADDR: stillness_threshold_low <= reg_req.wdata;
				`STILLNESS_THRESHOLD_HIGH_ADDR: stillness_threshold_high <= reg_req.wdata[`THRESHOLD_HIGH_BITS-1:0];
				`STILLNESS_COUNT_LOW_ADDR: stillness_count_low <= reg_req.wdata;
				`STILLNESS_COUNT_HIGH_ADDR: stillness_count_high <= reg_req.wdata;
				default: ;
			endcase
		end
	end

	logic [TW-1:0] motion_threshold;
	logic [TW-1:0] stillness_threshold;
	logic [15:0] stillness_count;

	assign motion_threshold = {motion_threshold_high, motion_threshold_low};
	assign stillness_threshold = {stillness_threshold_high, stillness_threshold_low};
	assign stillness_count = {stillness_count_high, stillness_count_low};

	// ==========================================================
	// power state
	motion_pkg::power_state_t power_state;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			power_state <= motion_pkg::PWR_STANDBY;
		end else if (restart_hit) begin
			power_state <= motion_pkg::PWR_STANDBY;
		end else if (measure_req) begin
			power_state <= motion_pkg::PWR_MEASURE;
		end
	end

	logic measuring;
	logic take_sample;

	assign measuring = power_state == motion_pkg::PWR_MEASURE;
	assign take_sample = sample.valid && measuring && !restart_hit;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			standby <= 1'b1;
		end else begin
			standby <= restart_hit || (!measure_req && !measuring);
		end
	end

	// ==========================================================
	// result storage, held as 12-bit values and extended on read
	logic [RW-1:0] z_result;
	logic [RW-1:0] temperature_result;
	logic [RW-1:0] aux_result;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			z_result <= '0;
			temperature_result <= '0;
			aux_result <= '0;
		end else if (restart_hit) begin
			z_result <= '0;
			temperature_result <= '0;
			aux_result <= '0;
		end else if (take_sample) begin
			z_result <= sample.z_accel;
			temperature_result <= sample.temperature;
			aux_result <= sample.aux_conv;
		end
	end

	function automatic logic [7:0] high_byte(input logic [RW-1:0] v);
		high_byte = {{`SIGN_EXT_BITS{v[RW-1]}}, v[RW-1:8]};
	endfunction

	// ==========================================================
	// register read: answer one clock after the request
	logic [7:0] next_rd_data;

	always_comb begin
		next_rd_data = `UNMAPPED_READ_VALUE;
		unique case (reg_req.addr)
			`Z_ACCEL_LOW_ADDR: next_rd_data = z_result[7:0];
			`Z_ACCEL_HIGH_ADDR: next_rd_data = high_byte(z_result);
			`TEMPERATURE_LOW_ADDR: next_rd_data = temperature_result[7:0];
			`TEMPERATURE_HIGH_ADDR: next_rd_data = high_byte(temperature_result);
			`AUX_CONV_LOW_ADDR: next_rd_data = aux_result[7:0];
			`AUX_CONV_HIGH_ADDR: next_rd_data = high_byte(aux_result);
			`SOFTWARE_RESTART_ADDR: next_rd_data = `RESTART_READ_VALUE;
			`MOTION_THRESHOLD_LOW_ADDR: next_rd_data = motion_threshold_low;
			`MOTION_THRESHOLD_HIGH_ADDR: next_rd_data = {5'h00, motion_threshold_high};
			`MOTION_DWELL_COUNT_ADDR: next_rd_data = motion_dwell_count;
			`STILLNESS_THRESHOLD_LOW_ADDR: next_rd_data = stillness_threshold_low;
			`STILLNESS_THRESHOLD_HIGH_ADDR: next_rd_data = {5'h00, stillness_threshold_high};
			`STILLNESS_COUNT_LOW_ADDR: next_rd_data = stillness_count_low;
			`STILLNESS_COUNT_HIGH_ADDR: next_rd_data = stillness_count_high;
			default: next_rd_data = `UNMAPPED_READ_VALUE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_data <= reg_req.rd ? next_rd_data : 8'h00;
			rd_valid <= reg_req.rd;
		end
	end

	// ==========================================================
	// per-axis magnitude against both thresholds
	function automatic logic [RW-1:0] magnitude(input logic [RW-1:0] v);
		// full-scale negative gives 2048, still representable unsigned
		magnitude = v[RW-1] ? RW'(~v + 1'b1) : v;
	endfunction

	logic [2:0][RW-1:0] axis;
	logic [2:0] axis_above;
	logic [2:0] axis_below;

	assign axis = {sample.z_accel, sample.y_accel, sample.x_accel};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_axis
			assign axis_above[g] = magnitude(axis[g]) > {1'b0, motion_threshold};
			assign axis_below[g] = magnitude(axis[g]) < {1'b0, stillness_threshold};
		end
	endgenerate

	logic motion_hit;
	logic still_hit;

	assign motion_hit = |axis_above;
	assign still_hit = &axis_below;

	// ==========================================================
	// consecutive-sample counters
	logic [7:0] motion_target;
	logic [16:0] still_target;
	logic [7:0] motion_run;
	logic [16:0] still_run;
	logic motion_done;
	logic still_done;

	// zero is read as one; wake-up mode always needs just one sample
	assign motion_target = (wake_mode || motion_dwell_count == 8'h00) ? 8'h01 : motion_dwell_count;
	assign still_target = (stillness_count == 16'h0000) ? 17'h00001 : {1'b0, stillness_count};
	assign motion_done = take_sample && motion_hit && ({1'b0, motion_run} + 9'h001 >= {1'b0, motion_target});
	assign still_done = take_sample && still_hit && (still_run + 17'h00001 >= still_target);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			motion_run <= 8'h00;
		end else if (restart_hit) begin
			motion_run <= 8'h00;
		end else if (take_sample) begin
			if (!motion_hit || motion_done) begin
				motion_run <= 8'h00;
			end else begin
				motion_run <= motion_run + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			still_run <= 17'h00000;
		end else if (restart_hit) begin
			still_run <= 17'h00000;
		end else if (take_sample) begin
			if (!still_hit || still_done) begin
				still_run <= 17'h00000;
			end else begin
				still_run <= still_run + 17'h00001;
			end
		end
	end

	// ==========================================================
	// flags: a detection in the acknowledge cycle wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			motion_flag <= 1'b0;
			stillness_flag <= 1'b0;
		end else if (restart_hit) begin
			motion_flag <= 1'b0;
			stillness_flag <= 1'b0;
		end else begin
			motion_flag <= motion_done || (motion_flag && !flag_ack);
			stillness_flag <= still_done || (stillness_flag && !flag_ack);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			config_error <= 1'b1;
		end else if (restart_hit) begin
			config_error <= 1'b1;
		end else if (plain_write) begin
			config_error <= 1'b0;
		end
	end

	// ==========================================================
	// interrupt pin: released on restart until software writes again
	logic [1:0] int_pin_sync;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			int_pin_sync <= 2'b00;
			int_pin_oe <= 1'b0;
			int_pin_out <= 1'b0;
		end else begin
			int_pin_sync <= {int_pin_sync[0], int_pin_in};
			int_pin_oe <= !restart_hit && (int_pin_oe || plain_write);
			// while released, follow the synchronised kept level so re-enabling causes no glitch
			int_pin_out <= !restart_hit &&
				(int_pin_oe ? (motion_done || still_done || motion_flag || stillness_flag) : int_pin_sync[1]);
		end
	end

	// ==========================================================
	// checks
	sequence seq_restart_write;
		reg_req.wr && reg_req.addr == `SOFTWARE_RESTART_ADDR && reg_req.wdata == `SOFTWARE_RESTART_CODE;
	endsequence

	sequence seq_read_of(logic [7:0] a);
		reg_req.rd && reg_req.addr == a;
	endsequence

	a_z_low_byte: assert property (@(posedge ref_clk) disable iff (rst)
		seq_read_of(`Z_ACCEL_LOW_ADDR) |=> rd_valid && rd_data == $past(z_result[7:0]))
		else $error("z low byte read mismatch");

	a_sign_extension: assert property (@(posedge ref_clk) disable iff (rst)
		(seq_read_of(`Z_ACCEL_HIGH_ADDR) or seq_read_of(`TEMPERATURE_HIGH_ADDR) or seq_read_of(`AUX_CONV_HIGH_ADDR))
		|=> rd_data[7:4] == {4{rd_data[3]}})
		else $error("high byte not sign extended");

	a_temp_high_byte: assert property (@(posedge ref_clk) disable iff (rst)
		seq_read_of(`TEMPERATURE_HIGH_ADDR) |=> rd_data[3:0] == $past(temperature_result[11:8]))
		else $error("temperature high byte mismatch");

	a_aux_low_byte: assert property (@(posedge ref_clk) disable iff (rst)
		seq_read_of(`AUX_CONV_LOW_ADDR) |=> rd_data == $past(aux_result[7:0]))
		else $error("aux low byte mismatch");

	a_restart_clears: assert property (@(posedge ref_clk) disable iff (rst)
		seq_restart_write |=> standby && motion_threshold == '0 && stillness_count == 16'h0000 && !motion_flag)
		else $error("restart did not clear settings");

	a_restart_pin_release: assert property (@(posedge ref_clk) disable iff (rst)
		seq_restart_write ##1 !reg_req.wr [*2] |=> !int_pin_oe)
		else $error("interrupt pin driven after restart");

	a_restart_reads_zero: assert property (@(posedge ref_clk) disable iff (rst)
		seq_read_of(`SOFTWARE_RESTART_ADDR) |=> rd_valid && rd_data == 8'h00)
		else $error("restart register read not zero");

	a_motion_single: assert property (@(posedge ref_clk) disable iff (rst)
		take_sample && motion_hit && (wake_mode || motion_dwell_count == 8'h00) |=> motion_flag)
		else $error("single qualifying sample missed");

	a_motion_run_restart: assert property (@(posedge ref_clk) disable iff (rst)
		take_sample && !motion_hit |=> motion_run == 8'h00 && !$rose(motion_flag))
		else $error("motion run not restarted");

	a_stillness_set: assert property (@(posedge ref_clk) disable iff (rst)
		take_sample && still_hit && still_run + 17'h00001 >= {1'b0, stillness_count} |=> stillness_flag)
		else $error("stillness not flagged");

	a_config_error_clear: assert property (@(posedge ref_clk) disable iff (rst)
		reg_req.wr && !restart_hit |=> !config_error)
		else $error("configuration error not cleared by write");

endmodule

// file: logic/motion_regs.svh
// register offsets, field widths, reset values and codes of the motion result block
// assumes byte-wide registers on an eight-bit register address
`ifndef MOTION_REGS_SVH
`define MOTION_REGS_SVH

`define Z_ACCEL_LOW_ADDR 8'h12
`define Z_ACCEL_HIGH_ADDR 8'h13
`define TEMPERATURE_LOW_ADDR 8'h14
`define TEMPERATURE_HIGH_ADDR 8'h15
`define AUX_CONV_LOW_ADDR 8'h16
`define AUX_CONV_HIGH_ADDR 8'h17
`define SOFTWARE_RESTART_ADDR 8'h1F
`define MOTION_THRESHOLD_LOW_ADDR 8'h20
`define MOTION_THRESHOLD_HIGH_ADDR 8'h21
`define MOTION_DWELL_COUNT_ADDR 8'h22
`define STILLNESS_THRESHOLD_LOW_ADDR 8'h23
`define STILLNESS_THRESHOLD_HIGH_ADDR 8'h24
`define STILLNESS_COUNT_LOW_ADDR 8'h25
`define STILLNESS_COUNT_HIGH_ADDR 8'h26

`define SOFTWARE_RESTART_CODE 8'h52
`define REG_RESET_VALUE 8'h00
`define RESTART_READ_VALUE 8'h00
`define UNMAPPED_READ_VALUE 8'h00

`define RESULT_WIDTH 12
`define THRESHOLD_WIDTH 11
`define THRESHOLD_HIGH_BITS 3
`define SIGN_EXT_BITS 4

`endif

// file: logic/motion_pkg.sv
// types shared by the motion result block and its surroundings
// assumes the header of offsets and widths is on the include path
`include "motion_regs.svh"

package motion_pkg;

	// one register request from the host port, taken in a single clock
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// one synchronous set of sensor conversions
	typedef struct packed {
		logic valid;
		logic [`RESULT_WIDTH-1:0] x_accel;
		logic [`RESULT_WIDTH-1:0] y_accel;
		logic [`RESULT_WIDTH-1:0] z_accel;
		logic [`RESULT_WIDTH-1:0] temperature;
		logic [`RESULT_WIDTH-1:0] aux_conv;
	} sample_t;

	typedef enum logic [1:0] {
		PWR_STANDBY,
		PWR_MEASURE
	} power_state_t;

endpackage

// file: tb/motion_host_model.sv
// host side of the register port: single-cycle write and read strobes on ref_clk
// assumes the bench calls these tasks one at a time; requests change at the falling edge
`timescale 1ns/1ns
module motion_host_model (
	// clock
	input wire logic ref_clk,
	// register port
	output motion_pkg::reg_req_t reg_req,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	// =====================================================
	// bus cycles
	initial begin
		reg_req = '0;
	end

	// released lines show the inverse, so a stale address never passes for a held one
	task automatic release_bus();
		reg_req.wr = 1'b0;
		reg_req.rd = 1'b0;
		reg_req.addr = ~reg_req.addr;
		reg_req.wdata = ~reg_req.wdata;
	endtask

	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge ref_clk);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(negedge ref_clk);
		release_bus();
	endtask

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge ref_clk);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(negedge ref_clk);
		release_bus();
		for (int k = 0; k < 4 && rd_valid !== 1'b1; k++) begin
			@(negedge ref_clk);
		end
		data = (rd_valid === 1'b1) ? rd_data : 8'hXX;
	endtask
endmodule

// file: tb/tb_motion_detect_result_regs.sv
// self-checking bench for the motion result block, driven from the falling edge
// assumes the host model issues every register access
`timescale 1ns/1ns
`include "motion_regs.svh"
module tb_motion_detect_result_regs;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	motion_pkg::reg_req_t reg_req;
	motion_pkg::sample_t sample = '0;
	logic [7:0] rd_data;
	logic rd_valid;
	logic wake_mode = 1'b0;
	logic measure_req = 1'b0;
	logic flag_ack = 1'b0;
	logic motion_flag, stillness_flag, config_error, standby;
	logic int_pin_in, int_pin_out, int_pin_oe;
	logic keeper = 1'b0;
	int n_errors = 0;
	int n_compared = 0;

	always #50 ref_clk = ~ref_clk;
	// keeper holds the last driven level while the pin floats
	always @(posedge ref_clk) if (int_pin_oe === 1'b1) keeper <= int_pin_out;
	assign int_pin_in = (int_pin_oe === 1'b1) ? int_pin_out : keeper;

	motion_detect_result_regs motion_detect_result_regs_inst (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
		.rd_data(rd_data), .rd_valid(rd_valid), .sample(sample), .wake_mode(wake_mode),
		.measure_req(measure_req), .flag_ack(flag_ack), .motion_flag(motion_flag),
		.stillness_flag(stillness_flag), .config_error(config_error), .standby(standby),
		.int_pin_in(int_pin_in), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe));
	motion_host_model motion_host_model_inst (.ref_clk(ref_clk), .reg_req(reg_req), .rd_data(rd_data),
		.rd_valid(rd_valid));

	// =====================================================
	// helpers
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		motion_host_model_inst.write_reg(a, d);
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] got;
		motion_host_model_inst.read_reg(a, got);
		check_byte($sformatf("reg %h", a), exp, got);
	endtask
	// temperature and auxiliary values are fixed: one positive, one negative
	task automatic send(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
		@(negedge ref_clk);
		sample = '{valid: 1'b1, x_accel: x, y_accel: y, z_accel: z, temperature: 12'h3C7, aux_conv: 12'hF0E};
		@(negedge ref_clk);
		sample.valid = 1'b0;
	endtask
	task automatic ack();
		@(negedge ref_clk);
		flag_ack = 1'b1;
		@(negedge ref_clk);
		flag_ack = 1'b0;
		check_bit("motion_flag", 1'b0, motion_flag);
		check_bit("stillness_flag", 1'b0, stillness_flag);
	endtask

	// =====================================================
	// scenarios
	task automatic t_reset();
		check_bit("config_error", 1'b1, config_error);
		check_bit("standby", 1'b1, standby);
		check_bit("int_pin_oe", 1'b0, int_pin_oe);
		check_bit("int_pin_out", 1'b0, int_pin_out);
		for (int a = 8'h12; a <= 8'h26; a++) rd_check(8'(a), 8'h00);
	endtask
	task automatic t_registers();
		wr(8'h12, 8'h5A);
		check_bit("config_error", 1'b0, config_error);
		rd_check(8'h12, 8'h00);
		wr(8'h21, 8'hFF);
		wr(8'h24, 8'hFE);
		rd_check(8'h21, 8'h07);
		rd_check(8'h24, 8'h06);
	endtask
	task automatic t_results();
		@(negedge ref_clk);
		measure_req = 1'b1;
		@(negedge ref_clk);
		measure_req = 1'b0;
		check_bit("standby", 1'b0, standby);
		send(12'h000, 12'h000, 12'h8A5);
		check_bit("motion_flag", 1'b1, motion_flag);
		check_bit("int_pin_out", 1'b1, int_pin_out);
		rd_check(8'h12, 8'hA5);
		rd_check(8'h13, 8'hF8);
		rd_check(8'h14, 8'hC7);
		rd_check(8'h15, 8'h03);
		rd_check(8'h16, 8'h0E);
		rd_check(8'h17, 8'hFF);
	endtask
	task automatic t_motion();
		wr(8'h20, 8'h05);
		wr(8'h21, 8'h01);
		wr(8'h22, 8'h03);
		wr(8'h24, 8'h00);
		ack();
		send(12'h106, 12'h000, 12'h000);
		send(12'h000, 12'hEFA, 12'h000);
		send(12'h105, 12'hEFB, 12'h105);
		send(12'h000, 12'h000, 12'h106);
		send(12'h000, 12'h000, 12'h106);
		check_bit("motion_flag", 1'b0, motion_flag);
		send(12'h000, 12'h000, 12'h106);
		check_bit("motion_flag", 1'b1, motion_flag);
		ack();
		wake_mode = 1'b1;
		send(12'hEFA, 12'h000, 12'h000);
		check_bit("motion_flag", 1'b1, motion_flag);
		wake_mode = 1'b0;
		ack();
	endtask
	task automatic t_stillness();
		wr(8'h20, 8'hFF);
		wr(8'h21, 8'h07);
		wr(8'h23, 8'h10);
		wr(8'h25, 8'h02);
		wr(8'h26, 8'h01);
		rd_check(8'h26, 8'h01);
		send(12'hFF1, 12'h00F, 12'h000);
		send(12'h000, 12'h010, 12'h000);
		for (int i = 0; i < 257; i++) send(12'hFF1, 12'h001, 12'h00F);
		check_bit("stillness_flag", 1'b0, stillness_flag);
		send(12'h000, 12'h000, 12'hFF1);
		check_bit("stillness_flag", 1'b1, stillness_flag);
		ack();
		wr(8'h25, 8'h00);
		wr(8'h26, 8'h00);
		send(12'h000, 12'h000, 12'h000);
		check_bit("stillness_flag", 1'b1, stillness_flag);
		send(12'h000, 12'h000, 12'h123);
	endtask
	task automatic t_restart();
		check_bit("int_pin_oe", 1'b1, int_pin_oe);
		// any other code at the restart address is an ordinary write
		wr(`SOFTWARE_RESTART_ADDR, 8'h51);
		check_bit("stillness_flag", 1'b1, stillness_flag);
		check_bit("standby", 1'b0, standby);
		wr(`SOFTWARE_RESTART_ADDR, `SOFTWARE_RESTART_CODE);
		check_bit("int_pin_oe", 1'b0, int_pin_oe);
		check_bit("config_error", 1'b1, config_error);
		check_bit("standby", 1'b1, standby);
		check_bit("stillness_flag", 1'b0, stillness_flag);
		rd_check(8'h12, 8'h00);
		rd_check(8'h21, 8'h00);
		rd_check(8'h23, 8'h00);
		rd_check(`SOFTWARE_RESTART_ADDR, 8'h00);
		// released pin shows the level the keeper held when the flag was still up
		check_bit("int_pin_out", 1'b1, int_pin_out);
		send(12'h000, 12'h000, 12'h321);
		rd_check(8'h12, 8'h00);
	endtask

	task automatic report_and_stop();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		t_reset();
		t_registers();
		t_results();
		t_motion();
		t_stillness();
		t_restart();
		report_and_stop();
	end
	// about 660 cycles of traffic; the margin covers a slow read answer
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule
